/* File: src/dcpd_pkg.sv */
/*
  Constants for the coarse phase detector configuration block.
  Assumes an APB master with 32-bit data and byte addresses.
*/
package dcpd_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] cfg_offset = 8'h74;
  localparam logic [7:0] cfg_reset = 8'h85;
  // Bit 4 is unused and reads as zero
  localparam logic [7:0] cfg_write_mask = 8'hef;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int loss_en_bit = 7;
  localparam int wide_en_bit = 6;
  localparam int multi_bit = 5;
  localparam int limit_lsb = 0;
  localparam int limit_width = 4;
  // ----------------------------------------------------------------
  // Phase arithmetic
  // ----------------------------------------------------------------
  localparam int phase_width = 14;
  localparam logic [14:0] max_limit = 15'h1fff;
  localparam logic [3:0] max_limit_code = 4'hb;
  localparam logic [5:0] limit_shift_base = 6'h2;
endpackage

/* File: src/dcpd_phase_cond.sv */
/*
  Combinational phase conditioner: clamps the loop phase and
  compares the coarse phase error with the programmed limit.
  Assumes the caller registers both results.
*/
`timescale 1ns/1ns
module dcpd_phase_cond
(
  input wire logic signed [13:0] phase_in,
  input wire logic multicycle_eff,
  input wire logic [3:0] limit_code,
  output logic signed [13:0] phase_out,
  output logic exceed
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Fifteen bits so that the most negative value has a magnitude
  function automatic logic [14:0] dcpd_abs(input logic signed [13:0] v);
    logic [14:0] w;
    w = {v[13], v};
    dcpd_abs = v[13] ? 15'(-w) : w;
  endfunction

  function automatic logic [14:0] dcpd_limit(input logic [3:0] code);
    logic [5:0] sh;
    sh = {2'h0, code} + dcpd_pkg::limit_shift_base;
    if (code > dcpd_pkg::max_limit_code)
      dcpd_limit = dcpd_pkg::max_limit;
    else
      dcpd_limit = 15'((15'h1 << sh) - 15'h1);
  endfunction

  // ----------------------------------------------------------------
  // Conditioning
  // ----------------------------------------------------------------
  always_comb
  begin
    phase_out = phase_in;
    // RL4: multicycle result passed whole
    if (!multicycle_eff)
    begin
      // RL3: clamp to one cycle
      if (phase_in > 14'sd1)
        phase_out = 14'sd1;
      else if (phase_in < -14'sd1)
        phase_out = -14'sd1;
    end
    // RL5: error against coarse limit
    exceed = dcpd_abs(phase_in) > dcpd_limit(limit_code);
  end
endmodule

/* File: src/dcpd_top.sv */
/*
  APB configuration register and loop phase gating for the wide
  range coarse phase detector of the digital PLL.
  Assumes a single pclk domain and coarse phase samples that are
  synchronous to it, signed in whole input cycles.
*/
`timescale 1ns/1ns
// Summary of operation
// RL1: Wide detector off at 0, on at 1
// RL2: Wide enable feeds coarse results to loop
// RL3: Multicycle clear clamps loop phase to one
// RL4: Multicycle set passes full coarse phase
// RL5: Phase loss only when enabled, over limit
// RL6: Multicycle honoured only with wide enabled
module dcpd_top
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [13:0] coarse_phase,
  input wire logic coarse_phase_valid,
  output logic wide_detector_en,
  output logic multicycle_loop_response,
  output logic signed [13:0] loop_phase,
  output logic loop_phase_valid,
  output logic phase_loss
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] cfg_q, cfg_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic multi_q, multi_d;
  logic signed [13:0] phase_q, phase_d;
  logic pvalid_q, pvalid_d;
  logic loss_q, loss_d;
  logic signed [13:0] cond_phase;
  logic cond_exceed;
  logic hit, setup, wr_now;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Ready is registered from the setup cycle, so it is high in the first access cycle and no access waits
  assign hit = paddr == dcpd_pkg::cfg_offset;
  assign setup = psel && !penable;
  assign wr_now = psel && penable && pready_q && pwrite && hit;

  always_comb
  begin
    cfg_d = cfg_q;
    prdata_d = prdata_q;
    pready_d = setup;
    pslverr_d = setup && !hit;
    // RL1: software sets the detector enable
    if (wr_now)
      cfg_d = pwdata[7:0] & dcpd_pkg::cfg_write_mask;
    if (setup)
      prdata_d = hit ? {24'h0, cfg_q} : 32'h0;
  end

  // ----------------------------------------------------------------
  // Loop phase path
  // ----------------------------------------------------------------
  dcpd_phase_cond u_cond
  (
    .phase_in(coarse_phase),
    .multicycle_eff(multi_q),
    .limit_code(cfg_q[dcpd_pkg::limit_lsb +: dcpd_pkg::limit_width]),
    .phase_out(cond_phase),
    .exceed(cond_exceed)
  );

  always_comb
  begin
    // RL6: multicycle gated by wide enable
    multi_d = cfg_d[dcpd_pkg::wide_en_bit] && cfg_d[dcpd_pkg::multi_bit];
    phase_d = phase_q;
    // RL2: results reach loop only when on
    pvalid_d = coarse_phase_valid && cfg_q[dcpd_pkg::wide_en_bit];
    if (pvalid_d)
      phase_d = cond_phase;
    loss_d = loss_q;
    // RL5: loss needs enable and wide detector
    if (!cfg_q[dcpd_pkg::loss_en_bit] || !cfg_q[dcpd_pkg::wide_en_bit])
      loss_d = 1'b0;
    else if (coarse_phase_valid)
      loss_d = cond_exceed;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_q <= dcpd_pkg::cfg_reset;
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      multi_q <= 1'b0;
      phase_q <= 14'sd0;
      pvalid_q <= 1'b0;
      loss_q <= 1'b0;
    end
    else
    begin
      cfg_q <= cfg_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      multi_q <= multi_d;
      phase_q <= phase_d;
      pvalid_q <= pvalid_d;
      loss_q <= loss_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign wide_detector_en = cfg_q[dcpd_pkg::wide_en_bit];
  assign multicycle_loop_response = multi_q;
  assign loop_phase = phase_q;
  assign loop_phase_valid = pvalid_q;
  assign phase_loss = loss_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_wide_en_write: assert property ( // RL1
    @(posedge pclk) disable iff (!presetn)
    wr_now |=> wide_detector_en == $past(pwdata[dcpd_pkg::wide_en_bit]))
    else $error("wide enable not taken from write");

  a_wide_off_gate: assert property ( // RL2
    @(posedge pclk) disable iff (!presetn)
    loop_phase_valid |-> $past(coarse_phase_valid) &&
      $past(wide_detector_en))
    else $error("loop phase valid without wide detector");

  a_clamp_one: assert property ( // RL3
    @(posedge pclk) disable iff (!presetn)
    coarse_phase_valid && wide_detector_en && !multicycle_loop_response
      |=> loop_phase_valid && loop_phase <= 14'sd1 &&
      loop_phase >= -14'sd1)
    else $error("loop phase not clamped to one cycle");

  a_multi_pass: assert property ( // RL4
    @(posedge pclk) disable iff (!presetn)
    coarse_phase_valid && multicycle_loop_response
      |=> loop_phase == $past(coarse_phase))
    else $error("multicycle phase not passed whole");

  a_loss_disabled: assert property ( // RL5
    @(posedge pclk) disable iff (!presetn)
    !cfg_q[dcpd_pkg::loss_en_bit] |=> !phase_loss)
    else $error("phase loss raised while disabled");

  a_multi_gated: assert property ( // RL6
    @(posedge pclk) disable iff (!presetn)
    multicycle_loop_response ==
      (cfg_q[dcpd_pkg::wide_en_bit] && cfg_q[dcpd_pkg::multi_bit]))
    else $error("multicycle honoured without wide detector");

  a_unmapped_err: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && paddr != dcpd_pkg::cfg_offset |=> pslverr && pready)
    else $error("unmapped address not flagged");
endmodule

/* File: verif/dcpd_bench.sv */
/*
  Self-checking bench for dcpd_top: register and phase rows.
  Assumes APB answers in the access phase; waits on pready.
*/
`timescale 1ns/1ns
module dpll_coarse_phase_detector_cfg_bench;
  typedef struct packed {logic [7:0] cfg; logic [13:0] ph; logic v;
    logic [13:0] lp; logic loss;} dcpd_prow_s;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic signed [13:0] coarse_phase = 14'h0000;
  logic coarse_phase_valid = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, wide_detector_en, multicycle_loop_response;
  logic signed [13:0] loop_phase;
  logic loop_phase_valid, phase_loss, er;
  logic [31:0] rd;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  logic [17:0] rrow [6];
  dcpd_prow_s prow [10];
  dcpd_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .coarse_phase(coarse_phase), .coarse_phase_valid(coarse_phase_valid),
    .wide_detector_en(wide_detector_en),
    .multicycle_loop_response(multicycle_loop_response),
    .loop_phase(loop_phase), .loop_phase_valid(loop_phase_valid),
    .phase_loss(phase_loss));
  // ----------------------------------------------------------------
  // Clock, timeout, tasks
  // ----------------------------------------------------------------
  initial forever #4 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      results();
    end
  end
  task results();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Read data taken only at the pready edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Ends when pready is seen high; otherwise the cycle timeout ends this wait
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task pulse(input logic [13:0] ph);
    @(posedge pclk);
    coarse_phase <= ph;
    coarse_phase_valid <= 1'b1;
    @(posedge pclk);
    coarse_phase_valid <= 1'b0;
    #1;
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    rrow = '{{8'h00, 8'h00, 2'b00}, {8'h20, 8'h20, 2'b00},
      {8'h40, 8'h40, 2'b10}, {8'h60, 8'h60, 2'b11},
      {8'hff, 8'hef, 2'b11}, {8'h85, 8'h85, 2'b00}};
    prow = '{{8'h85, 14'h0014, 1'b0, 14'h0000, 1'b0},
      {8'hc5, 14'h00c8, 1'b1, 14'h0001, 1'b1},
      {8'hc5, 14'h3ff9, 1'b1, 14'h3fff, 1'b0},
      {8'he5, 14'h00c8, 1'b1, 14'h00c8, 1'b1},
      {8'he5, 14'h007f, 1'b1, 14'h007f, 1'b0},
      {8'he5, 14'h3f80, 1'b1, 14'h3f80, 1'b1},
      {8'h65, 14'h00c8, 1'b1, 14'h00c8, 1'b0},
      {8'hc0, 14'h0004, 1'b1, 14'h0001, 1'b1},
      {8'hcb, 14'h1fff, 1'b1, 14'h0001, 1'b0},
      {8'hef, 14'h2000, 1'b1, 14'h2000, 1'b1}};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h74, 32'h0);
    chk(rd, 32'h85);
    chk(er, 1'b0);
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, 8'h74, {24'h0, rrow[i][17:10]});
      apb(1'b0, 8'h74, 32'h0);
      chk(rd, {24'h0, rrow[i][9:2]});
      chk(wide_detector_en, rrow[i][1]);
      chk(multicycle_loop_response, rrow[i][0]);
    end
    for (int i = 0; i < 10; i++)
    begin
      apb(1'b1, 8'h74, {24'h0, prow[i].cfg});
      pulse(prow[i].ph);
      chk(loop_phase_valid, prow[i].v);
      if (prow[i].v)
        chk({18'h0, loop_phase}, {18'h0, prow[i].lp});
      chk(phase_loss, prow[i].loss);
    end
    // Unmapped write must leave the register alone
    apb(1'b1, 8'h78, 32'h0);
    chk(er, 1'b1);
    apb(1'b0, 8'h78, 32'h0);
    chk(rd, 32'h0);
    chk(er, 1'b1);
    apb(1'b0, 8'h74, 32'h0);
    chk(rd, 32'hef);
    apb(1'b1, 8'h74, 32'he5);
    pulse(14'h00c8);
    chk(phase_loss, 1'b1);
    apb(1'b1, 8'h74, 32'h65);
    @(posedge pclk);
    #1;
    chk(phase_loss, 1'b0);
    chk(loop_phase_valid, 1'b0);
    chk({18'h0, loop_phase}, 32'hc8);
    apb(1'b1, 8'h74, 32'he5);
    pulse(14'h00c8);
    chk(phase_loss, 1'b1);
    @(posedge pclk);
    presetn <= 1'b0;
    #1;
    chk(phase_loss, 1'b0);
    chk(wide_detector_en, 1'b0);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h74, 32'h0);
    chk(rd, 32'h85);
    chk(phase_loss, 1'b0);
    chk(multicycle_loop_response, 1'b0);
    chk(loop_phase_valid, 1'b0);
    chk({18'h0, loop_phase}, 32'h0);
    results();
  end
endmodule
